// [core/event_counter_pwm_output.sv]
// event-counter pwm unit: registers, single 16-bit counter and shared pin control
//
// Function
// - 8192-tick period, 512-tick low at phi/8
// - 16-bit read/write period compare register
// - low-width register sets low pulse length
// - low-width register 16 bits, write-only
// - counter runs as one 16-bit channel
// - standby after reset until cancel bit
// - enable starts pwm, deselects event input
// - documented settings give 93.75 percent high
// - clock select codes phi/2..64, sub/16
// - enable bit 1: run; 0: event input
// - mode bit 5 selects port or pulse pin
`timescale 1ns/10ps
`default_nettype none
`include "event_pwm_consts.svh"

module event_counter_pwm_output
  import event_pwm_pkg::*;
#(
  parameter int SUB_DIV = `SUBCLK_DIV_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdData_q,
  input  wire logic        pinIn,
  output logic             pinOut_q,
  output logic             pinOe_q,
  output logic             eventInput_q,
  output logic             eventSelected_q,
  output logic             portSelected_q,
  output logic             unitRunning_q
);

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  word_t       periodCmp_q;
  word_t       lowWidth_q;
  logic        pulseEnable_q;
  clk_sel_t    clkSel_q;
  logic        standbyCancel_q;
  logic        pinFunction_q;
  unit_state_t state_q;
  unit_state_t state_d;

  // --------------------------------------------------------------------------
  // counter state
  // --------------------------------------------------------------------------
  word_t       count_q;
  word_t       count_d;
  logic        pwmLevel_q;
  logic        pwmLevel_d;
  logic        tick;
  logic        levelNext;
  logic        runNext;
  logic        prescClear;

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  logic hitPeriod;
  logic hitWidth;
  logic hitEdge;
  logic hitClock;
  logic hitPortMode;
  logic hitHalt;
  logic wrPeriod;
  logic wrWidth;
  logic wrEdge;
  logic wrClock;
  logic wrPortMode;
  logic wrHalt;
  logic unitAwake;
  logic startPulse;
  logic running;
  word_t rdData_d;

  assign hitPeriod   = (regAddr == `OFS_PERIOD_CMP);
  assign hitWidth    = (regAddr == `OFS_LOW_WIDTH);
  assign hitEdge     = (regAddr == `OFS_EDGE_SELECT);
  assign hitClock    = (regAddr == `OFS_CLOCK_CTRL);
  assign hitPortMode = (regAddr == `OFS_PORT_ONE_MODE);
  assign hitHalt     = (regAddr == `OFS_CLOCK_HALT_2);

  // a module in standby ignores writes to its own registers
  assign unitAwake   = standbyCancel_q;
  assign wrPeriod    = regWrite && hitPeriod && unitAwake;
  assign wrWidth     = regWrite && hitWidth && unitAwake;
  assign wrEdge      = regWrite && hitEdge && unitAwake;
  assign wrClock     = regWrite && hitClock && unitAwake;
  assign wrPortMode  = regWrite && hitPortMode;
  assign wrHalt      = regWrite && hitHalt;

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  // the low-width register is write-only and reads as zero
  assign rdData_d =
      hitPeriod   ? periodCmp_q :
      hitWidth    ? 16'h0000 :
      hitEdge     ? {14'h0000, pulseEnable_q, 1'b0} :
      hitClock    ? {12'h000, clkSel_q, 1'b0} :
      hitPortMode ? {10'h000, pinFunction_q, 5'h00} :
      hitHalt     ? {12'h000, standbyCancel_q, 3'h0} :
                    16'h0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData_q <= `RST_READ_DATA;
    end else if (regRead) begin
      regRdData_q <= rdData_d;
    end else begin
      regRdData_q <= `RST_READ_DATA;
    end
  end

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  // writes while running are stored as given; software must halt first
  // to change period, width or clock, since the counter compares live values
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periodCmp_q <= `RST_PERIOD_CMP;
    end else if (wrPeriod) begin
      periodCmp_q <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lowWidth_q <= `RST_LOW_WIDTH;
    end else if (wrWidth) begin
      lowWidth_q <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulseEnable_q <= 1'b0;
    end else if (wrEdge) begin
      pulseEnable_q <= regWrData[`BIT_PULSE_ENABLE];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkSel_q <= `RST_CLKSEL;
    end else if (wrClock) begin
      clkSel_q <= regWrData[`BIT_CLKSEL_HI:`BIT_CLKSEL_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      standbyCancel_q <= 1'b0;
    end else if (wrHalt) begin
      standbyCancel_q <= regWrData[`BIT_STANDBY_CANCEL];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinFunction_q <= 1'b0;
    end else if (wrPortMode) begin
      pinFunction_q <= regWrData[`BIT_PIN_FUNCTION];
    end
  end

  // --------------------------------------------------------------------------
  // unit state
  // --------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      UNIT_STANDBY: begin
        if (unitAwake) begin
          state_d = UNIT_HALTED;
        end
      end
      UNIT_HALTED: begin
        if (!unitAwake) begin
          state_d = UNIT_STANDBY;
        end else if (pulseEnable_q) begin
          state_d = UNIT_RUNNING;
        end
      end
      UNIT_RUNNING: begin
        if (!unitAwake) begin
          state_d = UNIT_STANDBY;
        end else if (!pulseEnable_q) begin
          state_d = UNIT_HALTED;
        end
      end
      default: begin
        state_d = UNIT_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= UNIT_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end

  assign running    = (state_q == UNIT_RUNNING);
  // entry into running restarts both the prescaler and the counter
  assign startPulse = (state_q != UNIT_RUNNING) && (state_d == UNIT_RUNNING);

  // --------------------------------------------------------------------------
  // run control
  // --------------------------------------------------------------------------
  // the next state decides the pin, so pin and run flag change at one edge
  assign runNext    = (state_d == UNIT_RUNNING);
  // a stopped unit holds its prescaler cleared, so every start is alike
  assign prescClear = !running || startPulse;

  // --------------------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------------------
  pwm_prescaler #(
    .SUB_DIV (SUB_DIV)
  ) u_prescaler (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (prescClear),
    .sel     (clkSel_q),
    .tick_q  (tick)
  );

  // --------------------------------------------------------------------------
  // single 16-bit counter and waveform
  // --------------------------------------------------------------------------
  // one period is compare+1 ticks; the pin is low for data+1 ticks of it;
  // a width at or above the period keeps the pin low throughout
  assign count_d    = (count_q == periodCmp_q) ? 16'h0000 : count_q + 16'h0001;
  assign pwmLevel_d = (count_d > lowWidth_q);
  // level that pwmLevel_q takes at this edge; the pin copies it in step with
  // unitRunning_q, so the low phase shows at the very edge the unit starts
  assign levelNext  = startPulse ? 1'b0 :
                      (running && tick) ? pwmLevel_d : pwmLevel_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q    <= 16'h0000;
      pwmLevel_q <= 1'b1;
    end else if (startPulse) begin
      count_q    <= 16'h0000;
      pwmLevel_q <= 1'b0;
    end else if (!running) begin
      count_q    <= 16'h0000;
      pwmLevel_q <= 1'b1;
    end else if (tick) begin
      count_q    <= count_d;
      pwmLevel_q <= pwmLevel_d;
    end
  end

  // --------------------------------------------------------------------------
  // shared pin
  // --------------------------------------------------------------------------
  // in port mode the pin belongs to the general port logic, so nothing drives it here
  // a halted or stopping unit shows the idle high level on the pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinOut_q        <= 1'b1;
      pinOe_q         <= 1'b0;
      eventInput_q    <= 1'b0;
      eventSelected_q <= 1'b0;
      portSelected_q  <= 1'b1;
      unitRunning_q   <= 1'b0;
    end else begin
      pinOut_q        <= runNext ? levelNext : 1'b1;
      pinOe_q         <= pinFunction_q && runNext;
      eventSelected_q <= pinFunction_q && !runNext;
      eventInput_q    <= pinFunction_q && !runNext && pinIn;
      portSelected_q  <= !pinFunction_q;
      unitRunning_q   <= runNext;
    end
  end

endmodule // event_counter_pwm_output

`default_nettype wire

// [core/event_pwm_consts.svh]
// register offsets, field positions, reset values and timing counts of the event-counter pwm unit
`ifndef EVENT_PWM_CONSTS_SVH
`define EVENT_PWM_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFS_PERIOD_CMP    16'hFF8C
`define OFS_LOW_WIDTH     16'hFF8E
`define OFS_EDGE_SELECT   16'hFF92
`define OFS_CLOCK_CTRL    16'hFF94
`define OFS_PORT_ONE_MODE 16'hFFC0
`define OFS_CLOCK_HALT_2  16'hFFFB

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_PULSE_ENABLE   1
`define BIT_CLKSEL_LO      1
`define BIT_CLKSEL_HI      3
`define BIT_STANDBY_CANCEL 3
`define BIT_PIN_FUNCTION   5

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_PERIOD_CMP  16'h0000
`define RST_LOW_WIDTH   16'h0000
`define RST_CLKSEL      3'h0
`define RST_READ_DATA   16'h0000

// ----------------------------------------------------------------------------
// clock-select codes and timing
// ----------------------------------------------------------------------------
`define CLKSEL_SUB_DIV16 3'h6
`define CLKSEL_FORBIDDEN 3'h7
`define CLK_PERIOD_NS    40
`define SUBCLK_PERIOD_NS 30518
`define SUBCLK_DIV_CYC   (`SUBCLK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// [core/event_pwm_pkg.sv]
// types shared by the event-counter pwm unit
package event_pwm_pkg;

  typedef enum logic [1:0] {
    UNIT_STANDBY,
    UNIT_HALTED,
    UNIT_RUNNING
  } unit_state_t;

  typedef logic [2:0]  clk_sel_t;
  typedef logic [15:0] word_t;

endpackage

// [core/pwm_prescaler.sv]
// clock prescaler producing the counting enable of the event-counter pwm
`timescale 1ns/10ps
`default_nettype none
`include "event_pwm_consts.svh"

module pwm_prescaler
  import event_pwm_pkg::*;
#(
  parameter int SUB_DIV = `SUBCLK_DIV_CYC
) (
  input  wire logic     clk,
  input  wire logic     sys_rst,
  input  wire logic     clear,
  input  wire clk_sel_t sel,
  output logic          tick_q
);

  // --------------------------------------------------------------------------
  // dividers
  // --------------------------------------------------------------------------
  logic [5:0]  div_q;
  logic [15:0] subDiv_q;
  logic [3:0]  sub16_q;
  logic [5:0]  mask;
  logic        subTick;
  logic        mainHit;
  logic        sub16Hit;
  logic        tick_d;
  logic [15:0] subStart;
  logic [3:0]  sub16Start;

  // per-bit mask: code n divides by 2 to the power n+1
  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_mask
      assign mask[i] = (sel >= 3'(i));
    end
  endgenerate

  assign subTick  = (subDiv_q == 16'(SUB_DIV - 1));
  assign mainHit  = ((div_q & mask) == mask);
  assign sub16Hit = subTick && (sub16_q == 4'hF);
  // the forbidden code yields no tick, so a bad setting freezes rather than runs wild
  assign tick_d   = (sel == `CLKSEL_FORBIDDEN) ? 1'b0 :
                    (sel == `CLKSEL_SUB_DIV16) ? sub16Hit : mainHit;

  // clear loads the state one edge past zero: the registered tick costs a cycle,
  // and without this head start the first low phase would be one clock too long
  assign subStart   = (SUB_DIV == 1) ? 16'h0000 : 16'h0001;
  assign sub16Start = (SUB_DIV == 1) ? 4'h1 : 4'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q    <= 6'h00;
      subDiv_q <= 16'h0000;
      sub16_q  <= 4'h0;
      tick_q   <= 1'b0;
    end else if (clear) begin
      div_q    <= 6'h01;
      subDiv_q <= subStart;
      sub16_q  <= sub16Start;
      tick_q   <= 1'b0;
    end else begin
      div_q    <= div_q + 6'h01;
      subDiv_q <= subTick ? 16'h0000 : subDiv_q + 16'h0001;
      sub16_q  <= subTick ? sub16_q + 4'h1 : sub16_q;
      tick_q   <= tick_d;
    end
  end

endmodule // pwm_prescaler

`default_nettype wire

// [bench/pwm_load_model.sv]
// external load on the shared pulse pin, with a pull-up
`timescale 1ns/10ps
`default_nettype none

module pwm_load_model (
  input  wire logic pinOut,
  input  wire logic pinOe,
  input  wire logic extOe,
  input  wire logic extLevel,
  output logic      pinLevel
);
  // --------------------------------------------------
  // pin level
  // --------------------------------------------------
  // a released pin floats up through the pull-up, never keeps its last value
  assign pinLevel = pinOe ? pinOut : (extOe ? extLevel : 1'b1);
endmodule // pwm_load_model

`default_nettype wire

// [bench/event_counter_pwm_output_assertions.sv]
// port assertions of the event-counter pwm unit
`timescale 1ns/10ps
`default_nettype none

module event_counter_pwm_output_assertions #(
  parameter int SUB_DIV = 2
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdData_q,
  input wire logic        pinIn,
  input wire logic        pinOut_q,
  input wire logic        pinOe_q,
  input wire logic        eventInput_q,
  input wire logic        eventSelected_q,
  input wire logic        portSelected_q,
  input wire logic        unitRunning_q
);
  // --------------------------------------------------
  // properties
  // --------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  width_hidden_a: assert property (regRead && regAddr == 16'hFF8E |=> regRdData_q == 16'h0000)
    else $error("low width register read back nonzero");
  read_idle_a: assert property ($past(regRead) == 1'b0 |-> regRdData_q == 16'h0000)
    else $error("read data outside its cycle");
  drive_running_a: assert property (pinOe_q |-> unitRunning_q)
    else $error("pin driven while halted");
  event_off_a: assert property (unitRunning_q |-> !eventSelected_q && !eventInput_q)
    else $error("event input selected while running");
  halted_high_a: assert property (!unitRunning_q |-> pinOut_q)
    else $error("pin low while halted");
  port_mode_a: assert property (portSelected_q |-> !pinOe_q && !eventSelected_q)
    else $error("port pin also given to the unit");
  first_low_a: assert property ($rose(unitRunning_q) |-> !pinOut_q && pinOe_q)
    else $error("period does not start with the low pulse");
  start_cause_a: assert property ($rose(unitRunning_q) |-> $past(regWrite, 2) || $past(regWrite, 3))
    else $error("unit started without an enable write");
  event_copy_a: assert property (eventInput_q |-> $past(pinIn) && eventSelected_q)
    else $error("event input not taken from the pin");

  start_c: cover property ($rose(unitRunning_q));
  low_end_c: cover property (unitRunning_q && $rose(pinOut_q));
  event_c: cover property (eventInput_q);
endmodule // event_counter_pwm_output_assertions

bind event_counter_pwm_output event_counter_pwm_output_assertions #(.SUB_DIV(SUB_DIV)) i_chk (.*);

`default_nettype wire

// [bench/event_counter_pwm_output_tb.sv]
// self-checking testbench of the event-counter pwm unit
`timescale 1ns/10ps
`default_nettype none

module event_counter_pwm_output_tb;
  import event_pwm_pkg::*;
  // small subclock divider keeps the subclock case short
  localparam int SUB_DIV = 2;
  logic  clk       = 1'b0;
  logic  sys_rst   = 1'b1;
  word_t regAddr   = 16'h0000;
  word_t regWrData = 16'h0000;
  logic  regWrite  = 1'b0;
  logic  regRead   = 1'b0;
  logic  extOe     = 1'b0;
  logic  extLevel  = 1'b0;
  word_t regRdData_q;
  logic  pinIn, pinOut_q, pinOe_q, eventInput_q, eventSelected_q, portSelected_q, unitRunning_q;
  word_t v;
  int    lo, hi, tick;
  int    failures = 0;
  int    checked  = 0;

  always #20 clk = ~clk;

  event_counter_pwm_output #(.SUB_DIV(SUB_DIV)) i_event_counter_pwm_output (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData_q(regRdData_q), .pinIn(pinIn), .pinOut_q(pinOut_q), .pinOe_q(pinOe_q),
    .eventInput_q(eventInput_q), .eventSelected_q(eventSelected_q), .portSelected_q(portSelected_q),
    .unitRunning_q(unitRunning_q));
  pwm_load_model i_pwm_load_model (.pinOut(pinOut_q), .pinOe(pinOe_q), .extOe(extOe),
    .extLevel(extLevel), .pinLevel(pinIn));

  // --------------------------------------------------
  // bus and check tasks
  // --------------------------------------------------
  task automatic chk(input word_t seen, input word_t exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input word_t a, input word_t d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input word_t a, output word_t d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    d = regRdData_q;
  endtask

  // halts, reprograms, restarts, then times the first low and high phases
  task automatic run(input word_t sel, input word_t cmp, input word_t wid);
    wr(16'hFF92, 16'h0000);
    wr(16'hFF8C, cmp);
    wr(16'hFF8E, wid);
    wr(16'hFF94, sel << 1);
    wr(16'hFF92, 16'h0002);
    lo = 0;
    hi = 0;
    for (int i = 0; i < 9 && unitRunning_q !== 1'b1; i++) @(negedge clk);
    while (pinOut_q === 1'b0 && lo < 70000) begin
      lo++;
      @(negedge clk);
    end
    while (pinOut_q === 1'b1 && hi < 70000) begin
      hi++;
      @(negedge clk);
    end
  endtask

  task automatic finish_test;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic t_standby;
    chk(pinOut_q, 1'b1);
    chk(portSelected_q, 1'b1);
    wr(16'hFF8C, 16'h1234);
    wr(16'hFF92, 16'h0002);
    rd(16'hFF8C, v);
    chk(v, 16'h0000);
    chk(unitRunning_q, 1'b0);
  endtask

  task automatic t_regs;
    wr(16'hFFFB, 16'h0008);
    wr(16'hFFC0, 16'h0020);
    repeat (2) @(negedge clk);
    chk(portSelected_q, 1'b0);
    wr(16'hFF8C, 16'h1FFF);
    rd(16'hFF8C, v);
    chk(v, 16'h1FFF);
    wr(16'hFF8E, 16'h01FF);
    rd(16'hFF8E, v);
    chk(v, 16'h0000);
    rd(16'h0000, v);
    chk(v, 16'h0000);
    @(posedge clk);
    extOe <= 1'b1;
    extLevel <= 1'b0;
    repeat (2) @(negedge clk);
    chk(eventSelected_q, 1'b1);
    chk(eventInput_q, 1'b0);
    @(posedge clk);
    extOe <= 1'b0;
    repeat (2) @(negedge clk);
    chk(eventInput_q, 1'b1);
  endtask

  task automatic t_clocks;
    for (int s = 0; s < 7; s++) begin
      run(word_t'(s), 16'h0001, 16'h0000);
      tick = (s < 6) ? (2 << s) : 16 * SUB_DIV;
      chk(word_t'(lo), word_t'(tick));
      chk(word_t'(hi), word_t'(tick));
    end
  endtask

  task automatic t_documented;
    run(16'h0002, 16'h1FFF, 16'h01FF);
    chk(word_t'(lo), 16'h1000);
    chk(word_t'(hi), 16'hF000);
    chk(unitRunning_q, 1'b1);
    chk(eventSelected_q, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_standby();
    t_regs();
    t_clocks();
    t_documented();
    finish_test();
  end

  // the documented period alone needs about 66000 cycles
  initial begin
    #(40 * 100000);
    failures++;
    finish_test();
  end
endmodule // event_counter_pwm_output_tb

`default_nettype wire
